// ---- citf_cfg.svh ----
// timing and encoding constants for the capture/interval timer with filter
// assumes inclusion by bare name from the package and design files
`ifndef CITF_CFG_SVH
`define CITF_CFG_SVH
`define CITF_CNT_RST     8'h00
`define CITF_CNT_MAX     8'hff
`define CITF_FILT_TAPS   5
`define CITF_DIV64       64
`define CITF_DIV32       32
`define CITF_DIV2        2
`define CITF_CKS_D64     2'h0
`define CITF_CKS_D32     2'h1
`define CITF_CKS_D2      2'h2
`define CITF_CKS_W2      2'h3
`define CITF_CLR_NONE    2'h0
`define CITF_CLR_FALL    2'h1
`define CITF_CLR_RISE    2'h2
`define CITF_CLR_BOTH    2'h3
`endif

// ---- citf_pkg.sv ----
// types shared by the capture/interval timer files
// assumes citf_cfg.svh sits in the same folder
`include "citf_cfg.svh"
package citf_pkg;
	// power mode of the surrounding chip
	typedef enum logic [2:0] {
		CITF_ACTIVE   = 3'b000,
		CITF_SLEEP    = 3'b001,
		CITF_WATCH    = 3'b010,
		CITF_SUBACT   = 3'b011,
		CITF_SUBSLEEP = 3'b100,
		CITF_STANDBY  = 3'b101
	} citf_pmode_t;
endpackage : citf_pkg

// ---- citf_filter.sv ----
// five-tap majority-free match filter for the capture input
// assumes pin is synchronous to clk and samp_en is a one-cycle enable
`timescale 1ns/1ns
`include "citf_cfg.svh"
module citf_filter #(
	parameter int TAPS = `CITF_FILT_TAPS
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// sampling
	input  wire logic samp_en,  // sampling clock rising edge
	input  wire logic pin,      // raw capture level
	// result
	output logic      filt_out  // filtered level
);
	logic [TAPS-1:0] taps_q;  // shift chain of latched samples

	// shift pin in on each sampling edge [R3] [R1]
	always_ff @(posedge clk) begin
		if (rst) begin
			taps_q <= '0;
		end else if (samp_en) begin
			taps_q <= {taps_q[TAPS-2:0], pin};
		end
	end

	// output moves only when every tap agrees, else keeps old value [R1] [R4]
	always_ff @(posedge clk) begin
		if (rst) begin
			filt_out <= 1'b0;
		end else if (&taps_q) begin
			filt_out <= 1'b1;
		end else if (~|taps_q) begin
			filt_out <= 1'b0;
		end
	end

	// a held high input shows at the output within five samples plus one
	a_filter_match: assert property (@(posedge clk) disable iff (rst)
		(&taps_q) |=> filt_out) // [R1]
		else $error("filter output did not follow matching taps");
endmodule : citf_filter

// ---- citf_prescaler.sv ----
// free-running divider giving one-cycle enables for the count clocks
// assumes watch clock tick arrives as a one-cycle pulse in the clk domain
`timescale 1ns/1ns
module citf_prescaler (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// watch tick
	input  wire logic watch_tick,  // watch clock rising edge, already synchronised
	// enables
	output logic      en_d64,
	output logic      en_d32,
	output logic      en_d2,
	output logic      en_w2
);
	logic [5:0] div_q;   // system divider
	logic       wdiv_q;  // watch divider

	// system divider counts continuously
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= 6'h00;
		end else begin
			div_q <= div_q + 6'h01;
		end
	end

	// watch divider halves the watch tick rate
	always_ff @(posedge clk) begin
		if (rst) begin
			wdiv_q <= 1'b0;
		end else if (watch_tick) begin
			wdiv_q <= ~wdiv_q;
		end
	end

	// enables fire on the wrap of each divider stage
	assign en_d64 = (div_q == 6'h3f);
	assign en_d32 = (div_q[4:0] == 5'h1f);
	assign en_d2  = div_q[0];
	assign en_w2  = watch_tick & wdiv_q;
endmodule : citf_prescaler

// ---- citf_timer.sv ----
// 8-bit capture / interval timer with optional input noise filter
// assumes inputs other than watch_clk_lvl synchronous to clk; watch clock arrives as a raw level and is synchronised here
`timescale 1ns/1ns
`include "citf_cfg.svh"
// How it works
// [R1] five-sample filter updates only on full agreement
// [R2] filter samples system clock or selected clock
// [R3] filter samples input on each sampling edge
// [R4] filter valid after five matching samples
// [R5] source holds unfiltered pulses two clocks
// [R6] eight-bit counter, capture or interval mode
// [R7] reset zeroes mode, counter and captures
// [R8] reset selects divide-by-64 count clock
// [R9] select codes 64, 32, 2, watch/2
// [R10] edges copy count to rise/fall registers
// [R11] selected capture edge sets request flag
// [R12] edge select zero rising, one falling
// [R13] counter cleared on chosen capture edges
// [R14] clear codes none, fall, rise, both
// [R15] wrap sets high or low overflow flag
// [R16] overflow with enable sets request flag
// [R17] interval wrap sets low overflow flag
// [R18] flags cleared by zero after read
// [R19] mode or filter writes may fake edges
// [R20] unfiltered input gives separate edge pulses
// [R21] filtered edges lag five sampling periods
// [R22] watch and standby halt or hold
// [R23] sub modes run only on watch/2
// [R24] watch/2 tick synchronised to system clock
module citf_timer
	import citf_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// pins and chip state
	input  wire logic        capture_pin,       // external pulse input
	input  wire logic        watch_clk_lvl,     // raw watch clock level
	input  wire citf_pmode_t power_mode,        // chip power mode
	// port mode bits
	input  wire logic        capture_mode_select, // 1 capture, 0 interval
	input  wire logic        filter_enable,       // noise filter on
	// mode register write port
	input  wire logic        tmr_wr,            // write strobe
	input  wire logic [7:0]  tmr_wdata,         // write data
	input  wire logic        tmr_rd,            // read strobe, arms flag clears
	// interrupt side
	input  wire logic        timer_irq_enable,  // request enable
	input  wire logic        irq_flag_clr,      // software clears request flag
	output logic             timer_irq_request_flag,
	output logic             cpu_irq,
	// status
	output logic [7:0]       timer_mode_reg,
	output logic [7:0]       timer_count,
	output logic [7:0]       fall_capture_reg,
	output logic [7:0]       rise_capture_reg
);
	// ------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------
	logic       overflow_high_flag;   // bit 7
	logic       overflow_low_flag;    // bit 6
	logic       overflow_irq_enable;  // bit 5
	logic       capture_irq_edge_sel; // bit 4
	logic [1:0] count_clear_sel;      // bits 3:2
	logic [1:0] clock_select;         // bits 1:0
	logic       ovh_read_q;           // high flag read as one
	logic       ovl_read_q;           // low flag read as one

	// ------------------------------------------------------------
	// clocking
	// ------------------------------------------------------------
	logic en_d64, en_d32, en_d2, en_w2;
	logic wsync1_q, wsync2_q, wsync3_q;  // watch clock synchroniser
	logic watch_tick;
	logic sel_en;      // selected count enable
	logic run_ok;      // counter allowed to run in this power mode
	logic cnt_en;
	logic samp_en;     // filter sampling enable
	logic sub_mode;
	logic mreg_run;    // mode register writable

	// watch clock crosses into clk by two flops then edge detect [R24]
	always_ff @(posedge clk) begin
		if (rst) begin
			wsync1_q <= 1'b0;
			wsync2_q <= 1'b0;
			wsync3_q <= 1'b0;
		end else begin
			wsync1_q <= watch_clk_lvl;
			wsync2_q <= wsync1_q;
			wsync3_q <= wsync2_q;
		end
	end
	assign watch_tick = wsync2_q & ~wsync3_q;  // [R24]

	citf_prescaler u_pre (
		.clk        (clk),
		.rst        (rst),
		.watch_tick (watch_tick),
		.en_d64     (en_d64),
		.en_d32     (en_d32),
		.en_d2      (en_d2),
		.en_w2      (en_w2)
	);

	// choose the count clock by the select field [R8] [R9]
	always_comb begin
		unique case (clock_select)
			`CITF_CKS_D64: sel_en = en_d64;
			`CITF_CKS_D32: sel_en = en_d32;
			`CITF_CKS_D2:  sel_en = en_d2;
			`CITF_CKS_W2:  sel_en = en_w2;
		endcase
	end

	assign sub_mode = (power_mode == CITF_SUBACT) || (power_mode == CITF_SUBSLEEP);

	// power-mode gating of counter and filter [R22] [R23]
	always_comb begin
		unique case (power_mode)
			CITF_ACTIVE, CITF_SLEEP: run_ok = 1'b1;
			CITF_SUBACT, CITF_SUBSLEEP: run_ok = (clock_select == `CITF_CKS_W2);
			default: run_ok = 1'b0;  // watch, standby and illegal codes
		endcase
	end
	assign cnt_en  = sel_en & run_ok;
	// sampling uses system clock unless filter on; sub modes allow only watch/2 [R2] [R23]
	assign samp_en = (filter_enable ? sel_en : ~sub_mode) & run_ok;
	// mode register takes writes only in active and subactive
	assign mreg_run = (power_mode == CITF_ACTIVE) || (power_mode == CITF_SUBACT);

	// ------------------------------------------------------------
	// capture signal path
	// ------------------------------------------------------------
	logic filt_lvl;     // filtered level
	logic cap_lvl;      // internal capture level
	logic cap_prev_q;   // previous internal level
	logic cap_rise, cap_fall;

	citf_filter #(.TAPS(`CITF_FILT_TAPS)) u_filt (
		.clk      (clk),
		.rst      (rst),
		.samp_en  (samp_en),
		.pin      (capture_pin),
		.filt_out (filt_lvl)
	);

	// mode and filter bits switch the source live, so a toggle can fake an edge [R19]
	// interval mode feeds low, as an unused pin would
	assign cap_lvl = capture_mode_select & (filter_enable ? filt_lvl : capture_pin); // [R21]

	// edge detector; unfiltered input relies on two-clock pulses [R5] [R20]
	always_ff @(posedge clk) begin
		if (rst) begin
			cap_prev_q <= 1'b0;
		end else if (run_ok) begin
			cap_prev_q <= cap_lvl;
		end
	end
	assign cap_rise = run_ok & cap_lvl & ~cap_prev_q;   // [R20]
	assign cap_fall = run_ok & ~cap_lvl & cap_prev_q;   // [R20]

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	logic cnt_clear;
	logic wrap;

	// clear field decode [R13] [R14]
	always_comb begin
		unique case (count_clear_sel)
			`CITF_CLR_NONE: cnt_clear = 1'b0;
			`CITF_CLR_FALL: cnt_clear = cap_fall;
			`CITF_CLR_RISE: cnt_clear = cap_rise;
			`CITF_CLR_BOTH: cnt_clear = cap_rise | cap_fall;
		endcase
	end
	assign wrap = cnt_en & (timer_count == `CITF_CNT_MAX) & ~cnt_clear;

	// up-counter, clear wins over increment [R6] [R7] [R13]
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_count <= `CITF_CNT_RST;
		end else if (cnt_clear) begin
			timer_count <= `CITF_CNT_RST;
		end else if (cnt_en) begin
			timer_count <= timer_count + 8'h01;
		end
	end

	// capture registers hold the count seen at the edge [R10] [R7]
	always_ff @(posedge clk) begin
		if (rst) begin
			rise_capture_reg <= `CITF_CNT_RST;
			fall_capture_reg <= `CITF_CNT_RST;
		end else begin
			if (cap_rise) begin
				rise_capture_reg <= timer_count;
			end
			if (cap_fall) begin
				fall_capture_reg <= timer_count;
			end
		end
	end

	// ------------------------------------------------------------
	// mode register and flags
	// ------------------------------------------------------------
	logic set_ovh, set_ovl;
	// high flag only in capture mode; interval always low flag [R15] [R17]
	assign set_ovh = wrap & capture_mode_select & cap_lvl;
	assign set_ovl = wrap & ~(capture_mode_select & cap_lvl);

	// control fields written by software; reset zero selects /64 [R7] [R8]
	always_ff @(posedge clk) begin
		if (rst) begin
			overflow_irq_enable  <= 1'b0;
			capture_irq_edge_sel <= 1'b0;
			count_clear_sel      <= `CITF_CLR_NONE;
			clock_select         <= `CITF_CKS_D64;
		end else if (tmr_wr && mreg_run) begin
			overflow_irq_enable  <= tmr_wdata[5];
			capture_irq_edge_sel <= tmr_wdata[4];
			count_clear_sel      <= tmr_wdata[3:2];
			clock_select         <= tmr_wdata[1:0];
		end
	end

	// read-as-one arms a later clear-by-zero [R18]
	// an accepted write disarms unless a read comes in the same cycle, so a routine write of zeros cannot clear a flag set later
	always_ff @(posedge clk) begin
		if (rst) begin
			ovh_read_q <= 1'b0;
			ovl_read_q <= 1'b0;
		end else if (tmr_rd) begin
			ovh_read_q <= overflow_high_flag;
			ovl_read_q <= overflow_low_flag;
		end else if (tmr_wr && mreg_run) begin
			ovh_read_q <= 1'b0;
			ovl_read_q <= 1'b0;
		end
	end

	// hardware sets, only zero writes clear, set wins over clear [R18] [R15]
	always_ff @(posedge clk) begin
		if (rst) begin
			overflow_high_flag <= 1'b0;
			overflow_low_flag  <= 1'b0;
		end else begin
			if (set_ovh) begin
				overflow_high_flag <= 1'b1;
			end else if (tmr_wr && mreg_run && !tmr_wdata[7] && ovh_read_q) begin
				overflow_high_flag <= 1'b0;
			end
			if (set_ovl) begin
				overflow_low_flag <= 1'b1;
			end else if (tmr_wr && mreg_run && !tmr_wdata[6] && ovl_read_q) begin
				overflow_low_flag <= 1'b0;
			end
		end
	end

	assign timer_mode_reg = {overflow_high_flag, overflow_low_flag, overflow_irq_enable,
		capture_irq_edge_sel, count_clear_sel, clock_select};

	// ------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------
	logic cap_irq_evt, ovf_irq_evt;
	// edge select 0 rising, 1 falling [R11] [R12]
	assign cap_irq_evt = capture_irq_edge_sel ? cap_fall : cap_rise;
	assign ovf_irq_evt = overflow_irq_enable & (set_ovh | set_ovl);  // [R16] [R17]

	// request flag: set wins over software clear [R11] [R16]
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_irq_request_flag <= 1'b0;
		end else if (cap_irq_evt || ovf_irq_evt) begin
			timer_irq_request_flag <= 1'b1;
		end else if (irq_flag_clr) begin
			timer_irq_request_flag <= 1'b0;
		end
	end
	assign cpu_irq = timer_irq_request_flag & timer_irq_enable;  // [R11] [R16]

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_rise_capture: assert property (@(posedge clk) disable iff (rst)
		cap_rise |=> rise_capture_reg == $past(timer_count)) // [R10]
		else $error("rise capture missed count");
	a_fall_capture: assert property (@(posedge clk) disable iff (rst)
		cap_fall |=> fall_capture_reg == $past(timer_count)) // [R10]
		else $error("fall capture missed count");
	a_wrap_low: assert property (@(posedge clk) disable iff (rst)
		(wrap && !capture_mode_select) |=> overflow_low_flag && timer_count == 8'h00) // [R17]
		else $error("interval wrap missed low flag");
	a_wrap_high: assert property (@(posedge clk) disable iff (rst)
		(wrap && capture_mode_select && cap_lvl) |=> overflow_high_flag) // [R15]
		else $error("high wrap missed high flag");
	a_clear_both: assert property (@(posedge clk) disable iff (rst)
		(count_clear_sel == 2'h3 && (cap_rise || cap_fall)) |=> timer_count == 8'h00) // [R13]
		else $error("counter not cleared on edge");
	a_edge_irq: assert property (@(posedge clk) disable iff (rst)
		(capture_irq_edge_sel && cap_fall) |=> timer_irq_request_flag) // [R11]
		else $error("falling edge did not set request");
	a_ovf_irq: assert property (@(posedge clk) disable iff (rst)
		(overflow_irq_enable && wrap) |=> timer_irq_request_flag) // [R16]
		else $error("overflow did not set request");
	a_standby_halt: assert property (@(posedge clk) disable iff (rst)
		(power_mode == CITF_STANDBY) [*2] |-> $stable(timer_count)) // [R22]
		else $error("counter moved in standby");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		(overflow_low_flag && !ovl_read_q) |=> overflow_low_flag) // [R18]
		else $error("low flag cleared without read");
	a_irq_sticky: assert property (@(posedge clk) disable iff (rst) // [R11]
		(timer_irq_request_flag && !irq_flag_clr) |=> timer_irq_request_flag)
		else $error("request flag dropped without clear");
endmodule : citf_timer

// ---- citf_pulse_src.sv ----
// far-side model: the external source that drives the capture pin
// assumes the bench asks for a pulse by raising go for one clock
`timescale 1ns/1ns
module citf_pulse_src (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// request
	input  wire logic       go,     // start a pulse now
	input  wire logic [7:0] width,  // high time in clocks
	// pin
	output logic            pin     // capture level, low between pulses
);
	logic [7:0] left_q;  // clocks of high time still owed
	// ---------------------------------------------------------------
	// pulse shaping
	// ---------------------------------------------------------------
	// widths under two clocks are stretched, a shorter pulse could be lost
	always_ff @(posedge clk) begin
		if (rst) begin
			left_q <= 8'h00;
		end else if (go) begin
			left_q <= (width < 8'h02) ? 8'h02 : width;
		end else if (left_q != 8'h00) begin
			left_q <= left_q - 8'h01;
		end
	end
	// the pin is driven low outside pulses, like an idle source
	assign pin = (left_q != 8'h00);
endmodule : citf_pulse_src

// ---- citf_timer_tb.sv ----
// self-checking bench for the capture/interval timer
// assumes citf_pkg and the design files are compiled before it
`timescale 1ns/1ns
module citf_timer_tb;
	import citf_pkg::*;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic        clk, rst, watch_clk_lvl, capture_mode_select, filter_enable;
	logic        tmr_wr, tmr_rd, timer_irq_enable, irq_flag_clr, go;
	logic [7:0]  tmr_wdata, width, timer_mode_reg, timer_count;
	logic [7:0]  fall_capture_reg, rise_capture_reg, rise_prev, fall_prev, c, ec;
	logic        capture_pin, timer_irq_request_flag, cpu_irq;
	citf_pmode_t power_mode;
	logic [7:0]  rq[$];  // expected rise captures
	logic [7:0]  fq[$];  // expected fall captures
	int          n_mismatch, total_checks, seed;
	// ---------------------------------------------------------------
	// instances
	// ---------------------------------------------------------------
	citf_timer u_citf_timer (.clk(clk), .rst(rst), .capture_pin(capture_pin),
		.watch_clk_lvl(watch_clk_lvl), .power_mode(power_mode),
		.capture_mode_select(capture_mode_select), .filter_enable(filter_enable),
		.tmr_wr(tmr_wr), .tmr_wdata(tmr_wdata), .tmr_rd(tmr_rd),
		.timer_irq_enable(timer_irq_enable), .irq_flag_clr(irq_flag_clr),
		.timer_irq_request_flag(timer_irq_request_flag), .cpu_irq(cpu_irq),
		.timer_mode_reg(timer_mode_reg), .timer_count(timer_count),
		.fall_capture_reg(fall_capture_reg), .rise_capture_reg(rise_capture_reg));
	citf_pulse_src u_citf_pulse_src (.clk(clk), .rst(rst), .go(go), .width(width),
		.pin(capture_pin));
	// ---------------------------------------------------------------
	// clocks
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// slow watch clock, one level every three system clocks
	initial begin
		watch_clk_lvl = 1'b0;
		forever begin
			repeat (3) @(posedge clk);
			#5 watch_clk_lvl = ~watch_clk_lvl;
		end
	end
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : step
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d);
		tmr_wr = 1'b1;
		tmr_wdata = d;
		step(1);
		tmr_wr = 1'b0;
		step(1);  // let an edge pass so a following write is a fresh request
	endtask : wr
	task automatic pulse(input logic [7:0] w, input int low);
		logic [7:0] c0;  // count when called
		// start on a count step, so the divide-by-two phase and the captures are fixed
		c0 = timer_count;
		while (timer_count == c0) begin
			step(1);
		end
		go = 1'b1;
		width = w;
		step(1);
		go = 1'b0;
		step(int'(w) + low);
	endtask : pulse
	task automatic clr_flag();
		irq_flag_clr = 1'b1;
		step(1);
		irq_flag_clr = 1'b0;
	endtask : clr_flag
	task automatic conclude();
		if (rq.size() + fq.size() != 0) n_mismatch++;  // a capture never came
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude
	// ---------------------------------------------------------------
	// capture watcher: a changed capture register takes the oldest note
	// ---------------------------------------------------------------
	// pulses start on a count step, so each captured count is exact
	// limitation: a capture equal to the old value is unseen; conclude then flags the note
	always @(posedge clk) begin
		#1;
		if (!rst && rise_capture_reg !== rise_prev && rq.size() > 0) begin
			ec = rq.pop_front();
			chk(rise_capture_reg, ec);
		end
		if (!rst && fall_capture_reg !== fall_prev && fq.size() > 0) begin
			ec = fq.pop_front();
			chk(fall_capture_reg, ec);
		end
		rise_prev = rise_capture_reg;
		fall_prev = fall_capture_reg;
	end
	// watchdog, far beyond the planned run
	initial begin
		#(20000 * 100);
		n_mismatch++;
		conclude();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		seed = 32'ha629;
		rst = 1'b1; power_mode = CITF_ACTIVE; capture_mode_select = 1'b0;
		filter_enable = 1'b0; tmr_wr = 1'b0; tmr_wdata = 8'h00; tmr_rd = 1'b0;
		timer_irq_enable = 1'b1; irq_flag_clr = 1'b0; go = 1'b0; width = 8'h00;
		step(4);
		rst = 1'b0;
		chk(timer_mode_reg, 8'h00);
		chk({timer_count, rise_capture_reg, fall_capture_reg} == 24'h0, 1'b1);
		// one divide-by-64 step fits in the first 70 clocks, the second does not
		step(70);
		chk(timer_count, 8'h01);
		// interval mode, divide by two, overflow interrupt on
		wr(8'h22);
		step(540);
		chk(timer_mode_reg[7:6], 2'b01);
		chk({timer_irq_request_flag, cpu_irq}, 2'b11);
		tmr_rd = 1'b1;
		step(1);
		tmr_rd = 1'b0;
		wr(8'h22);
		chk(timer_mode_reg[7:6], 2'b00);
		wr(8'he2);
		chk(timer_mode_reg[7:6], 2'b00);
		// sleep refuses writes, the mode register keeps its value
		power_mode = CITF_SLEEP;
		wr(8'h01);
		chk(timer_mode_reg, 8'h22);
		// standby refuses writes and halts the count
		power_mode = CITF_STANDBY;
		c = timer_count;
		wr(8'h01);
		step(3);
		chk(timer_mode_reg, 8'h22);
		chk(timer_count, c);
		power_mode = CITF_WATCH;
		c = timer_count;
		step(20);
		chk(timer_count, c);
		power_mode = CITF_SUBACT;
		step(20);
		chk(timer_count, c);
		wr(8'h23);
		step(40);
		chk(timer_count != c, 1'b1);
		power_mode = CITF_ACTIVE;
		// capture mode, clear on both edges, rising edge requests
		wr(8'h0e);
		capture_mode_select = 1'b1;
		step(4);
		clr_flag();
		// twenty high clocks hold nine whole divide-by-two steps after the rise clear
		fq.push_back(8'h09);
		pulse(8'h14, 30);
		width = 8'h16 + 8'($unsigned($random(seed)) % 16);
		rq.push_back(8'h0f);
		fq.push_back((width - 8'h01) >> 1);
		pulse(width, 10);
		chk({timer_irq_request_flag, cpu_irq}, 2'b11);
		timer_irq_enable = 1'b0;
		step(1);
		chk(cpu_irq, 1'b0);
		// falling edge selected, clear on falling: the rise must not request
		wr(8'h16);
		clr_flag();
		go = 1'b1;
		width = 8'h14;
		step(1);
		go = 1'b0;
		step(10);
		chk(timer_irq_request_flag, 1'b0);
		step(20);
		chk(timer_irq_request_flag, 1'b1);
		// long high level, cleared on rising only: the wrap lands while high
		wr(8'h0a);
		repeat (3) begin
			go = 1'b1;
			width = 8'hc8;
			step(1);
			go = 1'b0;
			step(190);
		end
		chk(timer_mode_reg[7:6], 2'b10);
		step(20);
		// filter on, sampling at divide by two
		wr(8'h02);
		filter_enable = 1'b1;
		step(20);
		clr_flag();
		pulse(8'h03, 20);
		chk(timer_irq_request_flag, 1'b0);
		pulse(8'h10, 20);
		chk(timer_irq_request_flag, 1'b1);
		// divide by 32: exactly two steps in any 64 clocks
		wr(8'h01);
		c = timer_count;
		step(64);
		chk(timer_count - c, 8'h02);
		conclude();
	end
endmodule : citf_timer_tb
